// [ivt_map.svh]
// offsets, field positions, opcodes and reset values of the instruction executor
// assumes inclusion by bare name from the control register, timer and executor modules
// ----------------------------------------------------------------
// Operation
// - disable instruction clears the global interrupt enable flag
// - enable instruction sets the global interrupt enable flag
// - enable bit 0 low and request set: clear request, skip next
// - enable bit 0 high: request test is a no-op, no clear, no skip
// - select bit 2 low: pin test skips when the pin is low
// - select bit 2 high: pin test skips when the pin is high
// - read and write paths between A and first interrupt control register
// - read and write paths between A and second interrupt control register
// - read and write paths between A and external interrupt control register
// - auxiliary timer control is write only, loaded from A
// - read and write paths between A and first, second timer control
// - read and write paths between A and fifth, sixth timer control
// - prescaler read: live count high nibble to B, low to A
// - prescaler write: B high, A low into count and reload together
// - timer 1 read: count bits 7..4 to B, bits 3..0 to A
// - timer 1 write: B:A into count and first reload at once
// - second reload write: B:A into second reload only, count untouched
// ----------------------------------------------------------------
`ifndef IVT_MAP_SVH
`define IVT_MAP_SVH
// opcodes of the executed group
`define IVT_OP_DI     10'h3F0
`define IVT_OP_EI     10'h3F1
`define IVT_OP_SNZ0   10'h038
`define IVT_OP_SNZI0  10'h03A
`define IVT_OP_RD_V1  10'h054
`define IVT_OP_WR_V1  10'h03F
`define IVT_OP_RD_V2  10'h055
`define IVT_OP_WR_V2  10'h03E
`define IVT_OP_RD_I1  10'h253
`define IVT_OP_WR_I1  10'h217
`define IVT_OP_WR_PA  10'h2AA
`define IVT_OP_RD_W1  10'h24B
`define IVT_OP_WR_W1  10'h20E
`define IVT_OP_RD_W2  10'h24C
`define IVT_OP_WR_W2  10'h20F
`define IVT_OP_RD_W5  10'h24F
`define IVT_OP_WR_W5  10'h212
`define IVT_OP_RD_W6  10'h250
`define IVT_OP_WR_W6  10'h213
`define IVT_OP_RD_PS  10'h275
`define IVT_OP_WR_PS  10'h235
`define IVT_OP_RD_T1  10'h270
`define IVT_OP_WR_T1  10'h230
`define IVT_OP_WR_R2  10'h292
// control register file indexes
`define IVT_IDX_V1    3'h0
`define IVT_IDX_V2    3'h1
`define IVT_IDX_I1    3'h2
`define IVT_IDX_W1    3'h3
`define IVT_IDX_W2    3'h4
`define IVT_IDX_W5    3'h5
`define IVT_IDX_W6    3'h6
// field positions
`define IVT_EXT0_EN_BIT  0
`define IVT_PIN_SEL_BIT  2
`define IVT_T1_RUN_BIT   0
// bus byte offsets
`define IVT_ADR_STATUS   5'h00
`define IVT_ADR_IRQ      5'h04
`define IVT_ADR_TMR      5'h08
`define IVT_ADR_PS       5'h0C
`define IVT_ADR_T1       5'h10
// reset values
`define IVT_CTL_RST      4'h0
`define IVT_CNT_RST      8'hFF
`endif

// [ivt_pkg.sv]
// types shared by the instruction executor modules
// assumes ivt_map.svh is on the include path
`default_nettype none
package ivt_pkg;
   // fetched instruction with the accumulator pair
   typedef struct packed {
      logic       valid;
      logic [9:0] op;
      logic [3:0] acc;
      logic [3:0] regb;
   } ivt_instr_t;
   // write-back to A and B
   typedef struct packed {
      logic       acc_we;
      logic       regb_we;
      logic [3:0] acc;
      logic [3:0] regb;
   } ivt_wb_t;
   // decoded instruction kind
   typedef enum logic [3:0] {
      K_NONE, K_DI, K_EI, K_SNZ0, K_SNZI0, K_RD, K_WR, K_WR_PA,
      K_RD_PS, K_WR_PS, K_RD_T1, K_WR_T1, K_WR_R2
   } ivt_kind_t;
   // bus slave state
   typedef enum logic {BUS_IDLE, BUS_ACK} ivt_bus_st_t;
endpackage
`default_nettype wire

// [ivt_ctl_regs.sv]
// file of 4-bit control registers with two write ports
// assumes port a (instruction) has priority over port b (bus)
`timescale 1ns/1ns
`default_nettype none
`include "ivt_map.svh"
module ivt_ctl_regs #(
   parameter int N = 7,
   parameter int W = 4
) (
   input  wire logic                sys_clk_i,  // system clock
   input  wire logic                reset_i,    // async reset, high
   input  wire logic [N-1:0]        a_we_i,     // instruction load per entry
   input  wire logic [W-1:0]        a_wd_i,     // accumulator value
   input  wire logic [N-1:0]        b_we_i,     // bus load per entry
   input  wire logic [N-1:0][W-1:0] b_wd_i,     // bus data per entry
   output logic      [N-1:0][W-1:0] q_o         // register contents
);
   // ----------------------------------------------------------------
   // one entry per index
   // ----------------------------------------------------------------
   for (genvar g = 0; g < N; g++) begin : g_ent
      logic [W-1:0] q_r;
      logic [W-1:0] q_nxt;
      // all four bits load in one cycle; instruction wins a collision
      always_comb begin
         q_nxt = q_r;
         if (a_we_i[g]) begin
            q_nxt = a_wd_i;
         end else if (b_we_i[g]) begin
            q_nxt = b_wd_i[g];
         end
      end
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
         if (reset_i) begin
            q_r <= `IVT_CTL_RST;
         end else begin
            q_r <= q_nxt;
         end
      end
      assign q_o[g] = q_r;
   end
endmodule
`default_nettype wire

// [ivt_timer.sv]
// prescaler and timer 1 down-counters with their reload registers
// assumes loads come one at a time from the executor
`timescale 1ns/1ns
`default_nettype none
`include "ivt_map.svh"
module ivt_timer #(
   parameter int W = 8
) (
   input  wire logic         sys_clk_i,  // system clock
   input  wire logic         reset_i,    // async reset, high
   input  wire logic         run_i,      // timer 1 counts
   input  wire logic         ps_ld_i,    // load prescaler and reload
   input  wire logic         t1_ld_i,    // load timer 1 and first reload
   input  wire logic         r2_ld_i,    // load second reload
   input  wire logic [W-1:0] d_i,        // B:A value
   output logic      [W-1:0] ps_o,       // live prescaler count
   output logic      [W-1:0] psr_o,      // prescaler reload
   output logic      [W-1:0] t1_o,       // timer 1 count
   output logic      [W-1:0] r1_o,       // first reload
   output logic      [W-1:0] r2_o        // second reload
);
   logic [W-1:0] ps_r, psr_r, t1_r, r1_r, r2_r;
   logic [W-1:0] ps_nxt, psr_nxt, t1_nxt, r1_nxt, r2_nxt;
   logic         tick;
   // ----------------------------------------------------------------
   // counting and loads
   // ----------------------------------------------------------------
   // a load overrides the count step in the same cycle
   always_comb begin
      tick    = (ps_r == '0);
      ps_nxt  = tick ? psr_r : ps_r - 1'b1;
      psr_nxt = psr_r;
      t1_nxt  = t1_r;
      r1_nxt  = r1_r;
      r2_nxt  = r2_r;
      if (run_i && tick) begin
         t1_nxt = (t1_r == '0) ? r1_r : t1_r - 1'b1;
      end
      if (ps_ld_i) begin
         ps_nxt  = d_i;
         psr_nxt = d_i;
      end
      if (t1_ld_i) begin
         t1_nxt = d_i;
         r1_nxt = d_i;
      end
      if (r2_ld_i) begin
         r2_nxt = d_i;
      end
   end
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ps_r  <= `IVT_CNT_RST;
         psr_r <= `IVT_CNT_RST;
         t1_r  <= `IVT_CNT_RST;
         r1_r  <= `IVT_CNT_RST;
         r2_r  <= `IVT_CNT_RST;
      end else begin
         ps_r  <= ps_nxt;
         psr_r <= psr_nxt;
         t1_r  <= t1_nxt;
         r1_r  <= r1_nxt;
         r2_r  <= r2_nxt;
      end
   end
   assign ps_o  = ps_r;
   assign psr_o = psr_r;
   assign t1_o  = t1_r;
   assign r1_o  = r1_r;
   assign r2_o  = r2_r;
endmodule
`default_nettype wire

// [ivt_exec.sv]
// executor for interrupt, timer control and timer transfer instructions
// assumes the sequencer presents one instruction per valid cycle with A and B
`timescale 1ns/1ns
`default_nettype none
`include "ivt_map.svh"
module ivt_exec
   import ivt_pkg::*;
#(
   parameter logic [9:0] DI_OP = `IVT_OP_DI,
   parameter logic [9:0] EI_OP = `IVT_OP_EI
) (
   input  wire logic        sys_clk_i,          // 25 MHz clock
   input  wire logic        reset_i,            // async reset, high
   input  wire ivt_instr_t  instr_i,            // fetched instruction
   input  wire logic        ext0_event_i,       // ext0 request pulse
   input  wire logic        int_pin_i,          // interrupt pin level
   input  wire logic [4:0]  avs_address_i,      // byte address
   input  wire logic        avs_read_i,         // bus read
   input  wire logic        avs_write_i,        // bus write
   input  wire logic [31:0] avs_writedata_i,    // bus write data
   input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
   output logic      [31:0] avs_readdata_o,     // bus read data
   output logic             avs_waitrequest_o,  // bus stall
   output ivt_wb_t          wb_o,               // A and B write-back
   output logic             skip_o,             // next instr skipped
   output logic             global_irq_enable_flag_o, // interrupts on
   output logic             ext0_request_flag_o       // ext0 pending
);
   localparam int NCTL = 7;
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic        gie_r, gie_nxt;
   logic        ext0_r, ext0_nxt, ext0_clr;
   logic        skip_r, skip_nxt;
   logic        pa_r, pa_nxt;
   ivt_wb_t     wb_r, wb_nxt;
   ivt_kind_t   kind;
   logic [2:0]  idx;
   logic        exec;
   logic [3:0]  acc_in, regb_in;
   logic [NCTL-1:0]      ins_we, sw_we;
   logic [NCTL-1:0][3:0] sw_wd, ctl_q;
   logic        ps_ld, t1_ld, r2_ld;
   logic [7:0]  ps_cnt, ps_rel, t1_cnt, t1_r1, t1_r2;
   ivt_bus_st_t bus_r, bus_nxt;
   logic        wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt, rd_mux;

   assign acc_in  = instr_i.acc;
   assign regb_in = instr_i.regb;
   // a pending skip swallows the next valid instruction
   assign exec    = instr_i.valid && !skip_r;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // kind plus control register index; unknown opcodes decode to none
   always_comb begin
      kind = K_NONE;
      idx  = 3'h0;
      case (instr_i.op)
         DI_OP:          kind = K_DI;
         EI_OP:          kind = K_EI;
         `IVT_OP_SNZ0:   kind = K_SNZ0;
         `IVT_OP_SNZI0:  kind = K_SNZI0;
         `IVT_OP_RD_V1: begin kind = K_RD; idx = `IVT_IDX_V1; end
         `IVT_OP_WR_V1: begin kind = K_WR; idx = `IVT_IDX_V1; end
         `IVT_OP_RD_V2: begin kind = K_RD; idx = `IVT_IDX_V2; end
         `IVT_OP_WR_V2: begin kind = K_WR; idx = `IVT_IDX_V2; end
         `IVT_OP_RD_I1: begin kind = K_RD; idx = `IVT_IDX_I1; end
         `IVT_OP_WR_I1: begin kind = K_WR; idx = `IVT_IDX_I1; end
         `IVT_OP_RD_W1: begin kind = K_RD; idx = `IVT_IDX_W1; end
         `IVT_OP_WR_W1: begin kind = K_WR; idx = `IVT_IDX_W1; end
         `IVT_OP_RD_W2: begin kind = K_RD; idx = `IVT_IDX_W2; end
         `IVT_OP_WR_W2: begin kind = K_WR; idx = `IVT_IDX_W2; end
         `IVT_OP_RD_W5: begin kind = K_RD; idx = `IVT_IDX_W5; end
         `IVT_OP_WR_W5: begin kind = K_WR; idx = `IVT_IDX_W5; end
         `IVT_OP_RD_W6: begin kind = K_RD; idx = `IVT_IDX_W6; end
         `IVT_OP_WR_W6: begin kind = K_WR; idx = `IVT_IDX_W6; end
         `IVT_OP_WR_PA:  kind = K_WR_PA;
         `IVT_OP_RD_PS:  kind = K_RD_PS;
         `IVT_OP_WR_PS:  kind = K_WR_PS;
         `IVT_OP_RD_T1:  kind = K_RD_T1;
         `IVT_OP_WR_T1:  kind = K_WR_T1;
         `IVT_OP_WR_R2:  kind = K_WR_R2;
         default:        kind = K_NONE;
      endcase
   end

   // ----------------------------------------------------------------
   // execution
   // ----------------------------------------------------------------
   // a skip lasts exactly until the next valid instruction is consumed
   always_comb begin
      gie_nxt  = gie_r;
      ext0_clr = 1'b0;
      skip_nxt = instr_i.valid ? 1'b0 : skip_r;
      pa_nxt   = pa_r;
      wb_nxt   = '0;
      ins_we   = '0;
      ps_ld    = 1'b0;
      t1_ld    = 1'b0;
      r2_ld    = 1'b0;
      if (exec) begin
         case (kind)
            K_DI: gie_nxt = 1'b0;
            K_EI: gie_nxt = 1'b1;
            K_SNZ0: begin
               // with the enable bit set this is a plain no-op
               if (!ctl_q[`IVT_IDX_V1][`IVT_EXT0_EN_BIT] && ext0_r) begin
                  ext0_clr = 1'b1;
                  skip_nxt = 1'b1;
               end
            end
            K_SNZI0: begin
               if (ctl_q[`IVT_IDX_I1][`IVT_PIN_SEL_BIT]) begin
                  skip_nxt = int_pin_i;
               end else begin
                  skip_nxt = !int_pin_i;
               end
            end
            K_RD: begin
               wb_nxt.acc_we = 1'b1;
               wb_nxt.acc    = ctl_q[idx];
            end
            K_WR: ins_we[idx] = 1'b1;
            K_WR_PA: pa_nxt = acc_in[0];
            K_RD_PS: begin
               wb_nxt = '{1'b1, 1'b1, ps_cnt[3:0], ps_cnt[7:4]};
            end
            K_WR_PS: ps_ld = 1'b1;
            K_RD_T1: begin
               wb_nxt = '{1'b1, 1'b1, t1_cnt[3:0], t1_cnt[7:4]};
            end
            K_WR_T1: t1_ld = 1'b1;
            K_WR_R2: r2_ld = 1'b1;
            default: gie_nxt = gie_r;
         endcase
      end
      // a request arriving with the clear is kept
      ext0_nxt = ext0_event_i | (ext0_r & ~ext0_clr);
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         gie_r  <= 1'b0;
         ext0_r <= 1'b0;
         skip_r <= 1'b0;
         pa_r   <= 1'b0;
         wb_r   <= '0;
      end else begin
         gie_r  <= gie_nxt;
         ext0_r <= ext0_nxt;
         skip_r <= skip_nxt;
         pa_r   <= pa_nxt;
         wb_r   <= wb_nxt;
      end
   end

   // control registers: instruction port beats the bus port
   ivt_ctl_regs #(.N(NCTL), .W(4)) u_ctl (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .a_we_i    (ins_we),
      .a_wd_i    (acc_in),
      .b_we_i    (sw_we),
      .b_wd_i    (sw_wd),
      .q_o       (ctl_q)
   );

   // prescaler and timer 1
   ivt_timer #(.W(8)) u_tmr (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .run_i     (ctl_q[`IVT_IDX_W1][`IVT_T1_RUN_BIT]),
      .ps_ld_i   (ps_ld),
      .t1_ld_i   (t1_ld),
      .r2_ld_i   (r2_ld),
      .d_i       ({regb_in, acc_in}),
      .ps_o      (ps_cnt),
      .psr_o     (ps_rel),
      .t1_o      (t1_cnt),
      .r1_o      (t1_r1),
      .r2_o      (t1_r2)
   );

   // ----------------------------------------------------------------
   // avalon slave
   // ----------------------------------------------------------------
   // read mux; unmapped offsets read zero
   always_comb begin
      case (avs_address_i)
         `IVT_ADR_STATUS: rd_mux = {29'h0, skip_r, ext0_r, gie_r};
         `IVT_ADR_IRQ:    rd_mux = {20'h0, ctl_q[`IVT_IDX_I1],
                                    ctl_q[`IVT_IDX_V2], ctl_q[`IVT_IDX_V1]};
         `IVT_ADR_TMR:    rd_mux = {15'h0, pa_r,
                                    ctl_q[`IVT_IDX_W6], ctl_q[`IVT_IDX_W5],
                                    ctl_q[`IVT_IDX_W2], ctl_q[`IVT_IDX_W1]};
         `IVT_ADR_PS:     rd_mux = {16'h0, ps_rel, ps_cnt};
         `IVT_ADR_T1:     rd_mux = {8'h0, t1_r2, t1_r1, t1_cnt};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // one wait cycle; the write lands on the edge that sees wait low
   always_comb begin
      bus_nxt   = bus_r;
      wait_nxt  = 1'b1;
      rdata_nxt = rdata_r;
      sw_we     = '0;
      sw_wd     = '0;
      sw_wd[`IVT_IDX_V1] = avs_writedata_i[3:0];
      sw_wd[`IVT_IDX_V2] = avs_writedata_i[7:4];
      sw_wd[`IVT_IDX_I1] = avs_writedata_i[11:8];
      sw_wd[`IVT_IDX_W1] = avs_writedata_i[3:0];
      sw_wd[`IVT_IDX_W2] = avs_writedata_i[7:4];
      sw_wd[`IVT_IDX_W5] = avs_writedata_i[11:8];
      sw_wd[`IVT_IDX_W6] = avs_writedata_i[15:12];
      case (bus_r)
         BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               bus_nxt   = BUS_ACK;
               wait_nxt  = 1'b0;
               rdata_nxt = avs_read_i ? rd_mux : 32'h0000_0000;
            end
         end
         BUS_ACK: begin
            bus_nxt = BUS_IDLE;
            if (avs_write_i && avs_address_i == `IVT_ADR_IRQ) begin
               sw_we[`IVT_IDX_V1] = avs_byteenable_i[0];
               sw_we[`IVT_IDX_V2] = avs_byteenable_i[0];
               sw_we[`IVT_IDX_I1] = avs_byteenable_i[1];
            end
            if (avs_write_i && avs_address_i == `IVT_ADR_TMR) begin
               sw_we[`IVT_IDX_W1] = avs_byteenable_i[0];
               sw_we[`IVT_IDX_W2] = avs_byteenable_i[0];
               sw_we[`IVT_IDX_W5] = avs_byteenable_i[1];
               sw_we[`IVT_IDX_W6] = avs_byteenable_i[1];
            end
         end
         default: bus_nxt = BUS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bus_r   <= BUS_IDLE;
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         bus_r   <= bus_nxt;
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_readdata_o           = rdata_r;
   assign avs_waitrequest_o        = wait_r;
   assign wb_o                     = wb_r;
   assign skip_o                   = skip_r;
   assign global_irq_enable_flag_o = gie_r;
   assign ext0_request_flag_o      = ext0_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   AST_DI_CLEARS: assert property (exec && kind == K_DI |=> !gie_r)
      else $error("disable did not clear enable flag");
   AST_EI_SETS: assert property (exec && kind == K_EI |=> gie_r)
      else $error("enable did not set enable flag");
   AST_EXT0_SKIP: assert property (exec && kind == K_SNZ0 && ext0_r
      && !ctl_q[`IVT_IDX_V1][`IVT_EXT0_EN_BIT]
      |=> skip_r && (!ext0_r || $past(ext0_event_i)))
      else $error("request test failed to clear and skip");
   AST_EXT0_NOP: assert property (exec && kind == K_SNZ0
      && ctl_q[`IVT_IDX_V1][`IVT_EXT0_EN_BIT]
      |=> !skip_r && (ext0_r || !$past(ext0_r)))
      else $error("request test acted while enabled");
   AST_PIN_LOW: assert property (exec && kind == K_SNZI0
      && !ctl_q[`IVT_IDX_I1][`IVT_PIN_SEL_BIT]
      |=> skip_r == !$past(int_pin_i))
      else $error("low pin test wrong");
   AST_PIN_HIGH: assert property (exec && kind == K_SNZI0
      && ctl_q[`IVT_IDX_I1][`IVT_PIN_SEL_BIT]
      |=> skip_r == $past(int_pin_i))
      else $error("high pin test wrong");
   AST_WR_V1: assert property (exec && kind == K_WR && idx == `IVT_IDX_V1
      |=> ctl_q[`IVT_IDX_V1] == $past(acc_in))
      else $error("first irq control not loaded");
   AST_RD_ONLY_A: assert property (exec && kind == K_RD
      |=> wb_r.acc_we && !wb_r.regb_we ##1 (!wb_r.acc_we || $past(exec)))
      else $error("control read write-back wrong");
   AST_RD_PS: assert property (exec && kind == K_RD_PS
      |=> {wb_r.regb, wb_r.acc} == $past(ps_cnt) && wb_r.regb_we)
      else $error("prescaler read wrong");
   AST_WR_T1: assert property (exec && kind == K_WR_T1
      |=> t1_cnt == {$past(regb_in), $past(acc_in)} && t1_r1 == t1_cnt)
      else $error("timer 1 load wrong");
   AST_SUPPRESS: assert property (instr_i.valid && skip_r
      |=> !wb_r.acc_we && !wb_r.regb_we && !skip_r && gie_r == $past(gie_r))
      else $error("skipped instruction took effect");

   CVR_SKIP_EXT0: cover property (exec && kind == K_SNZ0 ##1 skip_r);
   CVR_PIN_SKIP:  cover property (exec && kind == K_SNZI0 ##1 skip_r);
   CVR_BUS_RD:    cover property (avs_read_i && !avs_waitrequest_o);
   CVR_T1_RD:     cover property (exec && kind == K_RD_T1);
endmodule
`default_nettype wire

// [ivt_seq_model.sv]
// sequencer stand-in: holds A and B and presents one instruction per request
// assumes the bench asks for each instruction and may load A and B with it
`timescale 1ns/1ns
`default_nettype none
module ivt_seq_model
   import ivt_pkg::*;
(
   input  wire logic       sys_clk_i, // system clock
   input  wire logic       reset_i,   // async reset, high
   input  wire logic       go_i,      // present an instruction
   input  wire logic       ld_i,      // override A and B
   input  wire logic [9:0] op_i,      // opcode
   input  wire logic [3:0] ld_acc_i,  // new A
   input  wire logic [3:0] ld_regb_i, // new B
   input  wire ivt_wb_t    wb_i,      // executor write-back
   output ivt_instr_t      instr_o    // to the executor
);
   logic [3:0] acc_r;
   logic [3:0] regb_r;
   // write-back lands in A and B; a bench load wins so stimulus stays exact
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         acc_r  <= 4'h0;
         regb_r <= 4'h0;
      end else if (ld_i) begin
         acc_r  <= ld_acc_i;
         regb_r <= ld_regb_i;
      end else begin
         if (wb_i.acc_we) acc_r <= wb_i.acc;
         if (wb_i.regb_we) regb_r <= wb_i.regb;
      end
   end
   // B is the high nibble, A the low one of every 8-bit pair
   assign instr_o = '{valid: go_i, op: op_i, acc: ld_i ? ld_acc_i : acc_r, regb: ld_i ? ld_regb_i : regb_r};
endmodule
`default_nettype wire

// [irq_timer_transfer_instr_exec_bench.sv]
// self-checking bench for the instruction executor
// assumes ivt_pkg, ivt_exec and ivt_seq_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module irq_timer_transfer_instr_exec_bench;
   import ivt_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        sys_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        go = 1'b0, ld = 1'b0, ev = 1'b0, pin = 1'b1, rd = 1'b0, wr = 1'b0;
   logic [9:0]  op = 10'h000;
   logic [3:0]  la = 4'h0, lb = 4'h0, be = 4'hF;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wd = 32'h0, rdat, got;
   logic        wreq, skip, gie, xflag;
   ivt_instr_t  instr;
   ivt_wb_t     wb;
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   typedef struct packed {logic [9:0] wop; logic [9:0] rop; logic [3:0] val;} ivt_row_t;
   // write opcode, read opcode, value for each 4-bit control register
   ivt_row_t rows [7] = '{'{10'h03F, 10'h054, 4'h6}, '{10'h03E, 10'h055, 4'h9}, '{10'h217, 10'h253, 4'h3},
      '{10'h20E, 10'h24B, 4'hA}, '{10'h20F, 10'h24C, 4'h5}, '{10'h212, 10'h24F, 4'hC}, '{10'h213, 10'h250, 4'hF}};
   always #20 sys_clk_i = ~sys_clk_i;
   ivt_seq_model seq (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .go_i(go), .ld_i(ld), .op_i(op),
      .ld_acc_i(la), .ld_regb_i(lb), .wb_i(wb), .instr_o(instr));
   ivt_exec dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .instr_i(instr), .ext0_event_i(ev),
      .int_pin_i(pin), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .wb_o(wb), .skip_o(skip),
      .global_irq_enable_flag_o(gie), .ext0_request_flag_o(xflag));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one instruction, sampled at the falling edge after it is taken
   task automatic exec(input logic [9:0] o, input logic [3:0] a, input logic [3:0] b);
      @(posedge sys_clk_i);
      go <= 1'b1; ld <= 1'b1; op <= o; la <= a; lb <= b;
      @(posedge sys_clk_i);
      go <= 1'b0; ld <= 1'b0;
      @(negedge sys_clk_i);
   endtask
   // bus cycle held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
      int k;
      k = 0;
      @(posedge sys_clk_i);
      rd <= ~w; wr <= w; adr <= a; wd <= d; be <= b;
      @(posedge sys_clk_i);
      while (wreq !== 1'b0 && k < 20) begin
         @(posedge sys_clk_i);
         k++;
      end
      if (k == 20) chk(32'hDEAD, 32'h0);
      got = rdat;
      rd <= 1'b0; wr <= 1'b0;
   endtask
   task automatic pulse_ext0();
      @(posedge sys_clk_i) ev <= 1'b1;
      @(posedge sys_clk_i) ev <= 1'b0;
      @(negedge sys_clk_i);
   endtask
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(negedge sys_clk_i);
      chk({wreq, skip, gie, xflag, wb}, {4'h8, 10'h0});
      foreach (rows[i]) begin
         exec(rows[i].wop, rows[i].val, 4'h0);
         exec(rows[i].rop, ~rows[i].val, 4'h0);
         chk({wb.acc_we, wb.acc}, {1'b1, rows[i].val});
      end
      exec(10'h2AA, 4'h1, 4'h0);
      bus(1'b0, 5'h08, 32'h0, 4'hF);
      chk(got[16:0], 17'h1FC5A);
      exec(10'h3F1, 4'h0, 4'h0);
      chk(gie, 1'b1);
      bus(1'b0, 5'h00, 32'h0, 4'hF);
      chk(got[0], 1'b1);
      exec(10'h3F0, 4'h0, 4'h0);
      chk(gie, 1'b0);
      // pin test in both polarities, each skip consumed by one instruction
      exec(10'h217, 4'h0, 4'h0);
      @(posedge sys_clk_i) pin <= 1'b0;
      exec(10'h03A, 4'h0, 4'h0);
      chk(skip, 1'b1);
      exec(10'h03A, 4'h0, 4'h0);
      chk(skip, 1'b0);
      @(posedge sys_clk_i) pin <= 1'b1;
      exec(10'h03A, 4'h0, 4'h0);
      chk(skip, 1'b0);
      exec(10'h217, 4'h4, 4'h0);
      exec(10'h03A, 4'h0, 4'h0);
      chk(skip, 1'b1);
      exec(10'h000, 4'h0, 4'h0);
      @(posedge sys_clk_i) pin <= 1'b0;
      exec(10'h03A, 4'h0, 4'h0);
      chk(skip, 1'b0);
      // request test: taken, suppressed write, untaken, then disabled
      exec(10'h03F, 4'h0, 4'h0);
      pulse_ext0();
      chk(xflag, 1'b1);
      exec(10'h038, 4'h0, 4'h0);
      chk({skip, xflag}, 2'b10);
      exec(10'h03F, 4'h5, 4'h0);
      exec(10'h054, 4'hF, 4'h0);
      chk(wb.acc, 4'h0);
      exec(10'h038, 4'h0, 4'h0);
      chk(skip, 1'b0);
      exec(10'h03F, 4'h1, 4'h0);
      pulse_ext0();
      exec(10'h038, 4'h0, 4'h0);
      chk({skip, xflag}, 2'b01);
      // timer 1 stands still while its run bit is 0
      exec(10'h230, 4'hA, 4'h5);
      exec(10'h270, 4'h0, 4'h0);
      chk({wb.regb_we, wb.acc_we, wb.regb, wb.acc}, 10'h35A);
      exec(10'h292, 4'h2, 4'h1);
      exec(10'h270, 4'h0, 4'h0);
      chk({wb.regb, wb.acc}, 8'h5A);
      bus(1'b0, 5'h10, 32'h0, 4'hF);
      chk(got[23:0], 24'h125A5A);
      exec(10'h235, 4'hC, 4'h3);
      bus(1'b0, 5'h0C, 32'h0, 4'hF);
      chk(got[15:8], 8'h3C);
      exec(10'h275, 4'h0, 4'h0);
      chk({wb.regb_we, wb.regb}, 5'h13);
      // bus lanes, unmapped offset, then a reset in mid-run
      bus(1'b1, 5'h04, 32'h0000_0F69, 4'h1);
      bus(1'b0, 5'h04, 32'h0, 4'hF);
      chk(got[11:0], 12'h469);
      bus(1'b1, 5'h08, 32'h0000_B7D0, 4'h2);
      bus(1'b0, 5'h08, 32'h0, 4'hF);
      chk(got[16:0], 17'h1B75A);
      bus(1'b0, 5'h14, 32'h0, 4'hF);
      chk(got, 32'h0);
      exec(10'h3F1, 4'h0, 4'h0);
      @(posedge sys_clk_i) reset_i <= 1'b1;
      @(posedge sys_clk_i) reset_i <= 1'b0;
      @(negedge sys_clk_i);
      chk({gie, xflag, skip}, 3'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
